// file: hw/sereq_defs.svh
// register indices, field positions, reset values and decode constants
// for the equalizer and eye-scan register bank; included by the package
`ifndef SEREQ_DEFS_SVH
`define SEREQ_DEFS_SVH

// register indices; byte address is four times the index
`define SEREQ_EQ_CTRL_IDX 10'h1C2
`define SEREQ_ZERO_IDX 10'h1C3
`define SEREQ_RATE_IDX 10'h1C8
`define SEREQ_EQUALIZER_LEVEL_PER_CHANNEL_IDX 10'h1D0
`define SEREQ_EQUALIZER_STATE_PER_CHANNEL_IDX 10'h1E0
`define SEREQ_ES_RUN_IDX 10'h1F0
`define SEREQ_ES_CFG_IDX 10'h1F1

// equalizer control fields
`define SEREQ_MODE_LSB 0
`define SEREQ_HOLD_BIT 2
`define SEREQ_ZOVR_BIT 3
`define SEREQ_LOVR_BIT 4

// per-lane setting and status fields
`define SEREQ_LEVEL_LSB 0
`define SEREQ_BOOST_LSB 5
`define SEREQ_UNDER_BIT 5
`define SEREQ_OVER_BIT 6
`define SEREQ_LEVEL_MAX 5'h10

// eye-scan fields
`define SEREQ_RUN_BIT 0
`define SEREQ_ESMODE_LSB 0
`define SEREQ_SCAN_LENGTH_SELECT_LSB 4

// reset values
`define SEREQ_EQ_CTRL_RST 5'h00
`define SEREQ_ZERO_RST 5'h00
`define SEREQ_RATE_RST 2'h0
`define SEREQ_EQUALIZER_LEVEL_PER_CHANNEL_RST 7'h08
`define SEREQ_ES_RUN_RST 1'h0
`define SEREQ_ES_CFG_RST 6'h00

// zero codes chosen from the line rate
`define SEREQ_ZERO_RATE01 5'h1F
`define SEREQ_ZERO_RATE2 5'h1B
`define SEREQ_ZERO_RATE3 5'h08

`endif

// file: hw/sereq_pkg.sv
// types shared by the equalizer register bank, its port checker and its bench
// assumes the defs header sits beside it on the include path
`include "sereq_defs.svh"

package sereq_pkg;

  // status arriving from one connected receiver lane
  typedef struct packed {
    logic over;
    logic under;
    logic [15:0] therm;
  } sereq_lstat_s;

  // settings driven to one connected receiver lane
  typedef struct packed {
    logic [1:0] boost;
    logic [4:0] level;
  } sereq_lset_s;

  typedef logic [9:0] sereq_idx_t;

endpackage

// file: hw/sereq_therm_count.sv
// counts the set bits of a thermometer-coded equalizer level
// assumes the code is stable in core_clk terms; purely combinational
`timescale 1ns/1ps

module sereq_therm_count #(
  parameter int W = 16
) (
  input wire logic [W-1:0] therm,
  output logic [$clog2(W+1)-1:0] count
);

  always_comb begin
    count = '0;
    for (int i = 0; i < W; i++) begin
      count = count + {{($clog2(W+1)-1){1'b0}}, therm[i]};
    end
  end

endmodule

// file: hw/sereq_regs.sv
// equalizer and eye-scan register bank on an Avalon-MM slave
// assumes a single core_clk domain and lane status synchronous to it
//
// Contract
// - override set: zero code drives all lanes
// - override clear: zero code follows line rate
// - zero codes map to fixed frequencies
// - sixteen lane settings from 01D0h upward
// - only lanes 6 and 14 are connected
// - boost field bits 6-5 selects gain
// - level override applies lane level 0..16
// - status bit 6 over, bit 5 under
// - applied level is thermometer bit count
// - sixteen read-only status registers at 01E0h
// - zero override is control bit 3
// - length field selects analyzed sample count
// - scan mode shared; reserved codes invalid
//
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/1ps
`include "sereq_defs.svh"

module sereq_regs import sereq_pkg::*; #(
  parameter int NUM_LANES = 16,
  parameter int LANE_A = 6,
  parameter int LANE_B = 14
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [11:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire sereq_lstat_s lane_status [2],
  output sereq_lset_s lane_setting [2],
  output logic level_override,
  output logic eq_hold,
  output logic [1:0] eq_mode,
  output logic [4:0] zero_code,
  output logic [8:0] zero_freq_mhz,
  output logic scan_start,
  output logic [3:0] scan_mode,
  output logic scan_mode_valid,
  output logic scan_auto_offset,
  output logic [16:0] scan_sample_count
);

  function automatic logic [4:0] rate_zero(input logic [1:0] rate);
    case (rate)
      2'h2: rate_zero = `SEREQ_ZERO_RATE2;
      2'h3: rate_zero = `SEREQ_ZERO_RATE3;
      default: rate_zero = `SEREQ_ZERO_RATE01;
    endcase
  endfunction

  // unlisted codes report zero
  function automatic logic [8:0] zero_mhz(input logic [4:0] code);
    case (code)
      5'h1F: zero_mhz = 9'h16D;
      5'h1E: zero_mhz = 9'h113;
      5'h1D: zero_mhz = 9'h0C3;
      5'h1B: zero_mhz = 9'h08C;
      5'h19: zero_mhz = 9'h069;
      5'h10: zero_mhz = 9'h04B;
      5'h08: zero_mhz = 9'h037;
      5'h00: zero_mhz = 9'h032;
      default: zero_mhz = 9'h000;
    endcase
  endfunction

  function automatic logic [16:0] samples(input logic [1:0] len);
    case (len)
      2'h0: samples = 17'h0007F;
      2'h1: samples = 17'h00408;
      2'h2: samples = 17'h01FFF;
      default: samples = 17'h0FFFF;
    endcase
  endfunction

  function automatic logic mode_ok(input logic [3:0] m);
    mode_ok = (m >= 4'h1 && m <= 4'h4) ||
              (m >= 4'h8 && m <= 4'hE && m != 4'hB);
  endfunction

  // true when idx falls in a 16-entry block starting at base
  function automatic logic in_block(input sereq_idx_t idx,
                                    input sereq_idx_t base);
    in_block = idx >= base && idx < base + 10'(NUM_LANES);
  endfunction

  logic ack_reg;
  logic [31:0] readdata_reg;
  logic [4:0] eq_ctrl_reg;
  logic [4:0] zero_reg;
  logic [1:0] rate_reg;
  logic run_reg;
  logic [5:0] es_cfg_reg;
  logic [6:0] equalizer_level_per_channel_reg [NUM_LANES];
  logic [7:0] equalizer_state_per_channel [NUM_LANES];
  logic [4:0] zero_code_reg;
  logic [8:0] zero_freq_reg;
  logic [16:0] samples_reg;
  logic mode_valid_reg;
  logic auto_reg;
  sereq_lset_s lset_reg [2];

  wire sereq_idx_t idx = avs_address[11:2];
  wire wr_fire = avs_write & ack_reg & avs_byteenable[0];
  wire [7:0] wb = avs_writedata[7:0];
  wire sel_ctrl = idx == `SEREQ_EQ_CTRL_IDX;
  wire sel_zero = idx == `SEREQ_ZERO_IDX;
  wire sel_rate = idx == `SEREQ_RATE_IDX;
  wire sel_run = idx == `SEREQ_ES_RUN_IDX;
  wire sel_cfg = idx == `SEREQ_ES_CFG_IDX;
  wire sel_eq = in_block(idx, `SEREQ_EQUALIZER_LEVEL_PER_CHANNEL_IDX);
  wire sel_eqs = in_block(idx, `SEREQ_EQUALIZER_STATE_PER_CHANNEL_IDX);
  wire [3:0] eq_lane = 4'(idx - `SEREQ_EQUALIZER_LEVEL_PER_CHANNEL_IDX);
  wire [3:0] eqs_lane = 4'(idx - `SEREQ_EQUALIZER_STATE_PER_CHANNEL_IDX);
  wire zovr = eq_ctrl_reg[`SEREQ_ZOVR_BIT];
  wire lovr = eq_ctrl_reg[`SEREQ_LOVR_BIT];
  wire [4:0] zero_next = zovr ? zero_reg : rate_zero(rate_reg);
  wire [3:0] es_mode = es_cfg_reg[`SEREQ_ESMODE_LSB +: 4];
  wire [1:0] es_len = es_cfg_reg[`SEREQ_SCAN_LENGTH_SELECT_LSB +: 2];

  // one wait cycle per access; ack marks the completing edge
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (avs_read | avs_write) & ~ack_reg;
    end
  end

  // status image; disconnected lanes read zero
  logic [4:0] lvl_cnt [2];
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_conn
      sereq_therm_count #(.W(16)) u_cnt (
        .therm(lane_status[g].therm),
        .count(lvl_cnt[g])
      );
    end
    for (g = 0; g < NUM_LANES; g++) begin : g_eqs
      if (g == LANE_A || g == LANE_B) begin : g_live
        localparam int K = (g == LANE_A) ? 0 : 1;
        assign equalizer_state_per_channel[g] = {1'b0, lane_status[K].over,
                              lane_status[K].under, lvl_cnt[K]};
      end else begin : g_dead
        assign equalizer_state_per_channel[g] = 8'h00;
      end
    end
  endgenerate

  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    if (sel_ctrl) begin
      rd_mux = {3'h0, eq_ctrl_reg};
    end else if (sel_zero) begin
      rd_mux = {3'h0, zero_reg};
    end else if (sel_rate) begin
      rd_mux = {6'h00, rate_reg};
    end else if (sel_eq) begin
      rd_mux = {1'b0, equalizer_level_per_channel_reg[eq_lane]};
    end else if (sel_eqs) begin
      rd_mux = equalizer_state_per_channel[eqs_lane];
    end else if (sel_run) begin
      rd_mux = {7'h00, run_reg};
    end else if (sel_cfg) begin
      rd_mux = {2'h0, es_cfg_reg};
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      readdata_reg <= 32'h0000_0000;
    end else if (avs_read & ~ack_reg) begin
      readdata_reg <= {24'h000000, rd_mux};
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      eq_ctrl_reg <= `SEREQ_EQ_CTRL_RST;
      zero_reg <= `SEREQ_ZERO_RST;
      rate_reg <= `SEREQ_RATE_RST;
      es_cfg_reg <= `SEREQ_ES_CFG_RST;
    end else if (wr_fire) begin
      if (sel_ctrl) begin
        eq_ctrl_reg <= wb[4:0];
      end
      if (sel_zero) begin
        zero_reg <= wb[4:0];
      end
      if (sel_rate) begin
        rate_reg <= wb[1:0];
      end
      if (sel_cfg) begin
        es_cfg_reg <= wb[5:0];
      end
    end
  end

  // run bit changes only by a software write
  always_ff @(posedge core_clk) begin
    if (reset) begin
      run_reg <= `SEREQ_ES_RUN_RST;
    end else if (wr_fire && sel_run) begin
      run_reg <= wb[`SEREQ_RUN_BIT];
    end
  end

  generate
    for (g = 0; g < NUM_LANES; g++) begin : g_eq
      always_ff @(posedge core_clk) begin
        if (reset) begin
          equalizer_level_per_channel_reg[g] <= `SEREQ_EQUALIZER_LEVEL_PER_CHANNEL_RST;
        end else if (wr_fire && sel_eq && eq_lane == 4'(g)) begin
          equalizer_level_per_channel_reg[g] <= wb[6:0];
        end
      end
    end
  endgenerate

  // registered outputs toward the receivers
  generate
    for (g = 0; g < 2; g++) begin : g_set
      localparam int L = (g == 0) ? LANE_A : LANE_B;
      wire [4:0] lvl = equalizer_level_per_channel_reg[L][`SEREQ_LEVEL_LSB +: 5];
      wire [4:0] lvl_cl = (lvl > `SEREQ_LEVEL_MAX) ? `SEREQ_LEVEL_MAX : lvl;
      always_ff @(posedge core_clk) begin
        if (reset) begin
          lset_reg[g] <= '0;
        end else begin
          lset_reg[g].boost <= equalizer_level_per_channel_reg[L][`SEREQ_BOOST_LSB +: 2];
          lset_reg[g].level <= lovr ? lvl_cl : 5'h00;
        end
      end
      assign lane_setting[g] = lset_reg[g];
    end
  endgenerate

  always_ff @(posedge core_clk) begin
    if (reset) begin
      zero_code_reg <= 5'h00;
      zero_freq_reg <= 9'h000;
      samples_reg <= 17'h00000;
      mode_valid_reg <= 1'b0;
      auto_reg <= 1'b0;
    end else begin
      zero_code_reg <= zero_next;
      zero_freq_reg <= zero_mhz(zero_next);
      samples_reg <= samples(es_len);
      mode_valid_reg <= mode_ok(es_mode);
      auto_reg <= mode_ok(es_mode) & es_mode[3];
    end
  end

  assign avs_readdata = readdata_reg;
  assign level_override = lovr;
  assign eq_hold = eq_ctrl_reg[`SEREQ_HOLD_BIT];
  assign eq_mode = eq_ctrl_reg[`SEREQ_MODE_LSB +: 2];
  assign zero_code = zero_code_reg;
  assign zero_freq_mhz = zero_freq_reg;
  assign scan_start = run_reg;
  assign scan_mode = es_mode;
  assign scan_mode_valid = mode_valid_reg;
  assign scan_auto_offset = auto_reg;
  assign scan_sample_count = samples_reg;

endmodule

// file: tb/sereq_regs_chk.sv
// port checker for the equalizer register bank
// bound to sereq_regs from the bench top; one clock, sync reset
`timescale 1ns/1ps

module sereq_regs_chk import sereq_pkg::*; (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [11:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire sereq_lstat_s lane_status [2],
  input wire sereq_lset_s lane_setting [2],
  input wire logic level_override,
  input wire logic [4:0] zero_code,
  input wire logic [8:0] zero_freq_mhz,
  input wire logic scan_start,
  input wire logic [3:0] scan_mode,
  input wire logic scan_mode_valid,
  input wire logic scan_auto_offset
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  wire logic done = !avs_waitrequest && (avs_read || avs_write);
  wire logic run_wr = done && avs_write && avs_address == 12'h7C0;
  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("no answer after one wait");
  a_run_hold: assert property (!run_wr |=> $stable(scan_start))
    else $error("run bit changed without a write");
  a_run_set: assert property (run_wr && avs_byteenable[0]
    |=> scan_start == $past(avs_writedata[0])) else $error("run bit lost");
  a_freq_top: assert property (zero_code == 5'h1F
    |-> zero_freq_mhz == 9'h16D) else $error("zero freq wrong");
  a_level_off: assert property (!level_override |=>
    lane_setting[0].level == 5'h00 && lane_setting[1].level == 5'h00)
    else $error("level driven without override");
  a_auto_valid: assert property (scan_auto_offset |-> scan_mode_valid)
    else $error("auto offset on invalid mode");
  a_auto_set: assert property (scan_mode inside {4'h8, 4'h9, 4'hA,
    4'hC, 4'hD, 4'hE} |=> scan_auto_offset && scan_mode_valid)
    else $error("auto offset missing on offset mode");
  a_mode_rsv: assert property (scan_mode inside {4'h0, 4'h5, 4'h6,
    4'h7, 4'hB, 4'hF} |=> !scan_mode_valid) else $error("bad mode valid");
  a_stat_read: assert property (done && avs_read && avs_address == 12'h798
    |-> avs_readdata == {25'h0, $past(lane_status[0].over),
    $past(lane_status[0].under),
    5'($countones($past(lane_status[0].therm)))})
    else $error("lane status readback wrong");
endmodule

// file: tb/sereq_regs_tb_top.sv
// self-checking bench for the equalizer register bank
// drives the avalon slave and lane status ports directly
`timescale 1ns/1ps

module sereq_regs_tb_top import sereq_pkg::*;;
  logic core_clk = 0, reset = 1, avs_read = 0, avs_write = 0;
  logic [11:0] avs_address = 12'h000;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h1;
  logic [31:0] avs_readdata, q;
  logic avs_waitrequest, level_override, eq_hold, scan_start;
  logic scan_mode_valid, scan_auto_offset;
  logic [1:0] eq_mode;
  logic [4:0] zero_code;
  logic [8:0] zero_freq_mhz;
  logic [3:0] scan_mode;
  logic [16:0] scan_sample_count;
  sereq_lstat_s lane_status [2] = '{default: '0};
  sereq_lset_s lane_setting [2];
  int err_total = 0;
  int n_tests = 0;
  logic [4:0] rz [4] = '{5'h1F, 5'h1F, 5'h1B, 5'h08};
  logic [4:0] zc [8] = '{5'h1F, 5'h1E, 5'h1D, 5'h1B, 5'h19, 5'h10, 5'h08,
    5'h00};
  logic [8:0] fq [8] = '{9'h16D, 9'h113, 9'h0C3, 9'h08C, 9'h069, 9'h04B,
    9'h037, 9'h032};
  logic [16:0] sl [4] = '{17'h0007F, 17'h00408, 17'h01FFF, 17'h0FFFF};
  logic [15:0] mv = 16'h771E;
  logic [15:0] ma = 16'h7700;

  sereq_regs uut (.core_clk, .reset, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .lane_status, .lane_setting, .level_override, .eq_hold, .eq_mode,
    .zero_code, .zero_freq_mhz, .scan_start, .scan_mode, .scan_mode_valid,
    .scan_auto_offset, .scan_sample_count);

  initial forever #4 core_clk = ~core_clk;

  task automatic results();
    if (err_total == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  // one bus cycle, then idle until derived outputs have settled
  task automatic xf(input logic w, input logic [11:0] a,
    input logic [7:0] d, input logic [3:0] be);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= be;
    avs_write <= w;
    avs_read <= !w;
    // hold the request until the edge that sees waitrequest low
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    xf(1'b1, a, d, 4'h1);
  endtask

  task automatic rd(input string n, input logic [11:0] a, logic [31:0] e);
    xf(1'b0, a, 8'h00, 4'h1);
    chk(n, e, q);
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    err_total++;
    results();
  end

  initial begin
    repeat (12) @(posedge core_clk);
    reset <= 1'b0;
    rd("ctrl", 12'h708, 32'h0);
    rd("zero", 12'h70C, 32'h0);
    wr(12'h708, 8'h17);
    chk("ctl", 32'hF, {28'h0, level_override, eq_hold, eq_mode});
    for (int i = 0; i < 16; i++) rd("lane", 12'h740 + 12'(4 * i), 32'h8);
    rd("cfg", 12'h7C4, 32'h0);
    chk("len", 32'h7F, {15'h0, scan_sample_count});
    for (int r = 0; r < 4; r++) begin
      wr(12'h720, 8'(r));
      chk("rate", {27'h0, rz[r]}, {27'h0, zero_code});
    end
    wr(12'h708, 8'h08);
    for (int i = 0; i < 8; i++) begin
      wr(12'h70C, {3'h0, zc[i]});
      chk("zc", {27'h0, zc[i]}, {27'h0, zero_code});
      chk("mhz", {23'h0, fq[i]}, {23'h0, zero_freq_mhz});
    end
    wr(12'h708, 8'h00);
    chk("zrt", 32'h08, {27'h0, zero_code});
    wr(12'h778, 8'h3F);
    wr(12'h740, 8'h25);
    chk("off", 32'h20, {25'h0, lane_setting[1]});
    wr(12'h708, 8'h10);
    for (int b = 0; b < 4; b++) begin
      wr(12'h758, {1'b0, 2'(b), 5'h10});
      chk("set6", {25'h0, 2'(b), 5'h10}, {25'h0, lane_setting[0]});
    end
    chk("set14", 32'h30, {25'h0, lane_setting[1]});
    rd("raw14", 12'h778, 32'h3F);
    rd("lane0", 12'h740, 32'h25);
    @(posedge core_clk);
    lane_status[0] <= '{1'b1, 1'b0, 16'h00FF};
    lane_status[1] <= '{1'b0, 1'b1, 16'hFFFF};
    rd("st6", 12'h798, 32'h48);
    rd("st14", 12'h7B8, 32'h30);
    wr(12'h798, 8'h00);
    rd("st6w", 12'h798, 32'h48);
    rd("st0", 12'h780, 32'h0);
    for (int m = 0; m < 16; m++) begin
      wr(12'h7C4, 8'(m));
      chk("esm", {26'h0, 4'(m), mv[m], ma[m]},
        {26'h0, scan_mode, scan_mode_valid, scan_auto_offset});
    end
    for (int l = 0; l < 4; l++) begin
      wr(12'h7C4, {2'h0, 2'(l), 4'h1});
      chk("len", {15'h0, sl[l]}, {15'h0, scan_sample_count});
    end
    wr(12'h7C0, 8'h01);
    repeat (40) @(posedge core_clk);
    chk("run", 32'h1, {31'h0, scan_start});
    xf(1'b1, 12'h7C0, 8'h00, 4'h0);
    rd("runbe", 12'h7C0, 32'h1);
    wr(12'h7C0, 8'h00);
    chk("stop", 32'h0, {31'h0, scan_start});
    wr(12'h800, 8'hFF);
    rd("gap", 12'h800, 32'h0);
    @(posedge core_clk);
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    rd("rst6", 12'h758, 32'h8);
    results();
  end
endmodule

bind sereq_regs sereq_regs_chk chk_i (.core_clk, .reset, .avs_address,
  .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
  .avs_waitrequest, .lane_status, .lane_setting, .level_override,
  .zero_code, .zero_freq_mhz, .scan_start, .scan_mode, .scan_mode_valid,
  .scan_auto_offset);
